//--- include/esb_pkg.sv
package esb_pkg;
   localparam logic [7:0] OP_SRC_LEVEL = 8'h04;
   localparam logic [7:0] OP_ICS_PROG = 8'h08;
   localparam logic [7:0] OP_ICS_WRITE = 8'h09;
   localparam logic [7:0] OP_ICS_READ = 8'h0A;
   localparam logic [7:0] OP_SOFTSTART = 8'h0C;
   localparam logic [7:0] RST_HIGH_ONE = 8'h41;
   localparam logic [7:0] RST_HIGH_TWO = 8'hA8;
   localparam logic [7:0] RST_LOW = 8'h32;
   localparam logic [31:0] RST_ICS = 32'h0000_0000;
   localparam logic [7:0] RST_SS_ONE = 8'h8B;
   localparam logic [7:0] RST_SS_TWO = 8'h9C;
   localparam logic [7:0] RST_SS_THREE = 8'h96;
   localparam logic [7:0] RST_SS_DUR = 8'h0F;
   localparam int RANGE_BIT = 7;
   localparam logic [7:0] HI_UPPER_MIN = 8'h21;
   localparam logic [7:0] HI_UPPER_MAX = 8'h4B;
   localparam logic [7:0] HI_LOWER_MIN = 8'h8E;
   localparam logic [7:0] HI_LOWER_MAX = 8'hCC;
   localparam logic [7:0] LOW_MIN = 8'h0F;
   localparam logic [7:0] LOW_MAX = 8'h4B;
   localparam int STR_LSB = 4;
   localparam int STR_W = 3;
   localparam int OFF_LSB = 0;
   localparam int OFF_W = 4;
   localparam logic [3:0] OFF_MIN = 4'h4;
   localparam int DUR_W = 2;
   localparam int LEN_W = 6;
   localparam logic [5:0] DUR_STEP_MS = 6'h0A;
   localparam logic [1:0] SRC_LAST = 2'h2;
   localparam logic [1:0] FOUR_LAST = 2'h3;
   localparam int PHASES = 3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SRC, ST_PROG, ST_ICW, ST_ICR, ST_SS
   } esb_state_t;

   typedef struct packed {
      esb_state_t st;
      logic [1:0] idx;
      logic progReq;
      logic [7:0] highOne;
      logic [7:0] highTwo;
      logic [7:0] low;
      logic [31:0] ics;
      logic [7:0] rdByte;
      logic [2:0][7:0] ssPhase;
      logic [7:0] ssDur;
   } esb_regs_t;
endpackage

//--- rtl/esb_cmd_decoder.sv
// Summary of operation
// - opcode 04 takes three bytes: first high, second high, low source level
// - reset levels: 41h first high, A8h second high, 32h low
// - high byte with bit 7 clear lies in 8.6V..17V range, 0.2V steps
// - second high byte with bit 7 set: 8Eh..CCh from 2.4V, 0.1V steps
// - low byte with bit 7 clear: -5V..-17V, other codes not applicable
// - opcode 08 programs initial code only while internal clock gate set
// - busy stays high during initial code programming until it completes
// - opcode 09 stores four bytes as initial code selection, unchanged
// - opcode 0A reads initial code selection back to host
// - opcode 0C takes four soft-start bytes, phases run one, two, three
// - reset soft-start phase bytes: 8Bh, 9Ch, 96h
// - phase bits 6:4 pick drive strength, 000 weakest to 111 strongest
// - phase bits 3:0 min gate-drive off time, below 0100 not applicable
// - duration byte: phase three 5:4, two 3:2, one 1:0, reset 0Fh
// - duration codes 00..11 give about 10, 20, 30, 40 ms
module esb_cmd_decoder (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic hostValid,
   input wire logic hostDc,
   input wire logic [7:0] hostByte,
   input wire logic readStrobe,
   input wire logic internalClockGateFlag,
   input wire logic progDone,
   output logic progReq,
   output logic busy,
   output logic [7:0] readByte,
   output logic [7:0] firstHighSourceLevel,
   output logic [7:0] secondHighSourceLevel,
   output logic [7:0] negativeSourceLevel,
   output logic firstHighUpper,
   output logic secondHighLower,
   output logic firstHighValid,
   output logic secondHighValid,
   output logic negativeValid,
   output logic [31:0] initialCodeSel,
   output logic [23:0] softstartPhases,
   output logic [7:0] softstartDurations,
   output logic [8:0] boosterDriveStrength,
   output logic [11:0] boosterGateDriveOffTime,
   output logic [2:0] offTimeValid,
   output logic [17:0] phaseLenMs
);
   esb_pkg::esb_regs_t s_r;
   esb_pkg::esb_regs_t s_nxt;
   logic opTaken;
   logic dataTaken;

   function automatic logic [7:0] icsByte(input logic [31:0] v, input logic [1:0] i);
      logic [7:0] b;
      case (i)
         2'h0: b = v[31:24];
         2'h1: b = v[23:16];
         2'h2: b = v[15:8];
         default: b = v[7:0];
      endcase
      return b;
   endfunction

   // bytes are dropped while programming: the host polls busy first
   assign opTaken = hostValid && !hostDc && s_r.st != esb_pkg::ST_PROG;
   assign dataTaken = hostValid && hostDc && s_r.st != esb_pkg::ST_PROG;

   always_comb begin
      s_nxt = s_r;
      s_nxt.progReq = 1'b0;
      if (opTaken) begin
         s_nxt.idx = 2'h0;
         s_nxt.st = esb_pkg::ST_IDLE;
         case (hostByte)
            esb_pkg::OP_SRC_LEVEL: s_nxt.st = esb_pkg::ST_SRC;
            esb_pkg::OP_ICS_PROG: begin
               // without the clock gate the command is dropped silently
               if (internalClockGateFlag) begin
                  s_nxt.st = esb_pkg::ST_PROG;
                  s_nxt.progReq = 1'b1;
               end
            end
            esb_pkg::OP_ICS_WRITE: s_nxt.st = esb_pkg::ST_ICW;
            esb_pkg::OP_ICS_READ: begin
               s_nxt.st = esb_pkg::ST_ICR;
               s_nxt.rdByte = icsByte(s_r.ics, 2'h0);
            end
            esb_pkg::OP_SOFTSTART: s_nxt.st = esb_pkg::ST_SS;
            default: s_nxt.st = esb_pkg::ST_IDLE;
         endcase
      end else if (dataTaken) begin
         s_nxt.idx = s_r.idx + 2'h1;
         case (s_r.st)
            esb_pkg::ST_SRC: begin
               case (s_r.idx)
                  2'h0: s_nxt.highOne = hostByte;
                  2'h1: s_nxt.highTwo = hostByte;
                  default: s_nxt.low = hostByte;
               endcase
               if (s_r.idx == esb_pkg::SRC_LAST) begin
                  s_nxt.st = esb_pkg::ST_IDLE;
               end
            end
            esb_pkg::ST_ICW: begin
               // byte A lands in the top after four shifts
               s_nxt.ics = {s_r.ics[23:0], hostByte};
               if (s_r.idx == esb_pkg::FOUR_LAST) begin
                  s_nxt.st = esb_pkg::ST_IDLE;
               end
            end
            esb_pkg::ST_SS: begin
               // stored as sent; bit 7 of phase bytes is the host's duty
               if (s_r.idx == esb_pkg::FOUR_LAST) begin
                  s_nxt.ssDur = hostByte;
                  s_nxt.st = esb_pkg::ST_IDLE;
               end else begin
                  s_nxt.ssPhase[s_r.idx] = hostByte;
               end
            end
            default: s_nxt.idx = s_r.idx;
         endcase
      end else if (s_r.st == esb_pkg::ST_ICR && readStrobe) begin
         // four bytes A..D, then wraps to A
         s_nxt.idx = s_r.idx + 2'h1;
         s_nxt.rdByte = icsByte(s_r.ics, s_r.idx + 2'h1);
      end
      if (s_r.st == esb_pkg::ST_PROG && progDone) begin
         s_nxt.st = esb_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_r.st <= esb_pkg::ST_IDLE;
         s_r.idx <= 2'h0;
         s_r.progReq <= 1'b0;
         s_r.highOne <= esb_pkg::RST_HIGH_ONE;
         s_r.highTwo <= esb_pkg::RST_HIGH_TWO;
         s_r.low <= esb_pkg::RST_LOW;
         s_r.ics <= esb_pkg::RST_ICS;
         s_r.rdByte <= 8'h00;
         s_r.ssPhase[0] <= esb_pkg::RST_SS_ONE;
         s_r.ssPhase[1] <= esb_pkg::RST_SS_TWO;
         s_r.ssPhase[2] <= esb_pkg::RST_SS_THREE;
         s_r.ssDur <= esb_pkg::RST_SS_DUR;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign progReq = s_r.progReq;
   assign busy = s_r.st == esb_pkg::ST_PROG;
   assign readByte = s_r.rdByte;
   assign firstHighSourceLevel = s_r.highOne;
   assign secondHighSourceLevel = s_r.highTwo;
   assign negativeSourceLevel = s_r.low;
   assign initialCodeSel = s_r.ics;
   assign softstartPhases = s_r.ssPhase;
   assign softstartDurations = s_r.ssDur;

   // only the second high level has a lower range
   assign firstHighUpper = !s_r.highOne[esb_pkg::RANGE_BIT];
   assign secondHighLower = s_r.highTwo[esb_pkg::RANGE_BIT];
   assign firstHighValid = s_r.highOne >= esb_pkg::HI_UPPER_MIN
      && s_r.highOne <= esb_pkg::HI_UPPER_MAX;
   assign secondHighValid = secondHighLower
      ? (s_r.highTwo >= esb_pkg::HI_LOWER_MIN && s_r.highTwo <= esb_pkg::HI_LOWER_MAX)
      : (s_r.highTwo >= esb_pkg::HI_UPPER_MIN && s_r.highTwo <= esb_pkg::HI_UPPER_MAX);
   assign negativeValid = s_r.low >= esb_pkg::LOW_MIN
      && s_r.low <= esb_pkg::LOW_MAX;

   for (genvar p = 0; p < esb_pkg::PHASES; p++) begin : g_phase
      assign boosterDriveStrength[p*esb_pkg::STR_W +: esb_pkg::STR_W] =
         s_r.ssPhase[p][esb_pkg::STR_LSB +: esb_pkg::STR_W];
      assign boosterGateDriveOffTime[p*esb_pkg::OFF_W +: esb_pkg::OFF_W] =
         s_r.ssPhase[p][esb_pkg::OFF_LSB +: esb_pkg::OFF_W];
      assign offTimeValid[p] =
         s_r.ssPhase[p][esb_pkg::OFF_LSB +: esb_pkg::OFF_W] >= esb_pkg::OFF_MIN;
      // approximate length only; the booster times phases itself
      assign phaseLenMs[p*esb_pkg::LEN_W +: esb_pkg::LEN_W] = 6'(({4'h0,
         s_r.ssDur[p*esb_pkg::DUR_W +: esb_pkg::DUR_W]} + 6'h01) * esb_pkg::DUR_STEP_MS);
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence progCmd;
      opTaken && hostByte == esb_pkg::OP_ICS_PROG;
   endsequence

   sequence paramByte(esb_pkg::esb_state_t st, logic [1:0] k);
      dataTaken && s_r.st == st && s_r.idx == k;
   endsequence

   chk_prog_gated: assert property (progCmd ##0 !internalClockGateFlag |=> !busy && !progReq)
      else $error("programming started without clock gate");
   chk_prog_start: assert property (progCmd ##0 internalClockGateFlag |=> progReq && busy ##1 !progReq)
      else $error("programming request not a single pulse");
   chk_busy_hold: assert property (busy && !progDone |=> busy)
      else $error("busy dropped before completion");
   chk_busy_release: assert property (busy && progDone |=> !busy)
      else $error("busy held after completion");
   chk_low_level: assert property (paramByte(esb_pkg::ST_SRC, 2'h2)
      |=> negativeSourceLevel == $past(hostByte) && s_r.st == esb_pkg::ST_IDLE)
      else $error("low level byte not stored last");
   chk_ics_write: assert property (paramByte(esb_pkg::ST_ICW, 2'h0) ##1 paramByte(esb_pkg::ST_ICW, 2'h1)
      ##1 paramByte(esb_pkg::ST_ICW, 2'h2) ##1 paramByte(esb_pkg::ST_ICW, 2'h3)
      |=> initialCodeSel[31:24] == $past(hostByte, 4) && initialCodeSel[7:0] == $past(hostByte))
      else $error("initial code bytes misordered");
   chk_ics_read: assert property (opTaken && hostByte == esb_pkg::OP_ICS_READ
      |=> readByte == initialCodeSel[31:24])
      else $error("readback does not start with first byte");
   chk_ss_dur: assert property (paramByte(esb_pkg::ST_SS, 2'h3)
      |=> softstartDurations == $past(hostByte) && s_r.st == esb_pkg::ST_IDLE)
      else $error("duration byte not stored");

   sequence srcOp;
      opTaken && hostByte == esb_pkg::OP_SRC_LEVEL;
   endsequence

   sequence ssOp;
      opTaken && hostByte == esb_pkg::OP_SOFTSTART;
   endsequence

   sequence srcParams;
      paramByte(esb_pkg::ST_SRC, 2'h0) ##1 paramByte(esb_pkg::ST_SRC, 2'h1)
         ##1 paramByte(esb_pkg::ST_SRC, 2'h2);
   endsequence

   sequence ssParams;
      paramByte(esb_pkg::ST_SS, 2'h0) ##1 paramByte(esb_pkg::ST_SS, 2'h1)
         ##1 paramByte(esb_pkg::ST_SS, 2'h2) ##1 paramByte(esb_pkg::ST_SS, 2'h3);
   endsequence

   // a new opcode restarts the byte count, so every command begins at byte A
   chk_src_decode: assert property (srcOp |=> s_r.st == esb_pkg::ST_SRC && s_r.idx == 2'h0)
      else $error("source level opcode not decoded");
   chk_ics_decode: assert property (opTaken && hostByte == esb_pkg::OP_ICS_WRITE
      |=> s_r.st == esb_pkg::ST_ICW && s_r.idx == 2'h0)
      else $error("initial code write opcode not decoded");
   chk_read_decode: assert property (opTaken && hostByte == esb_pkg::OP_ICS_READ
      |=> s_r.st == esb_pkg::ST_ICR)
      else $error("readback opcode not decoded");
   chk_ss_decode: assert property (ssOp |=> s_r.st == esb_pkg::ST_SS && s_r.idx == 2'h0)
      else $error("soft start opcode not decoded");
   chk_unknown_op: assert property (opTaken && hostByte != esb_pkg::OP_SRC_LEVEL
      && hostByte != esb_pkg::OP_ICS_PROG && hostByte != esb_pkg::OP_ICS_WRITE
      && hostByte != esb_pkg::OP_ICS_READ && hostByte != esb_pkg::OP_SOFTSTART
      |=> s_r.st == esb_pkg::ST_IDLE && !progReq)
      else $error("unknown opcode not ignored");
   chk_op_restart: assert property (opTaken |=> s_r.idx == 2'h0)
      else $error("opcode did not restart byte count");
   chk_idle_ignore: assert property (dataTaken && s_r.st == esb_pkg::ST_IDLE
      |=> s_r.st == esb_pkg::ST_IDLE)
      else $error("stray parameter byte changed state");

   // full walks: one byte a cycle, each field compared with what was sent
   chk_src_walk: assert property (srcOp ##1 srcParams |=> firstHighSourceLevel == $past(hostByte, 3)
      && secondHighSourceLevel == $past(hostByte, 2) && negativeSourceLevel == $past(hostByte))
      else $error("source level bytes misordered");
   chk_ss_walk: assert property (ssOp ##1 ssParams |=> softstartPhases == {$past(hostByte, 2),
      $past(hostByte, 3), $past(hostByte, 4)} && softstartDurations == $past(hostByte))
      else $error("soft start bytes misordered");
   chk_high_one: assert property (paramByte(esb_pkg::ST_SRC, 2'h0)
      |=> firstHighSourceLevel == $past(hostByte))
      else $error("first high level not stored");
   chk_high_two: assert property (paramByte(esb_pkg::ST_SRC, 2'h1)
      |=> secondHighSourceLevel == $past(hostByte))
      else $error("second high level not stored");
   chk_src_step: assert property (paramByte(esb_pkg::ST_SRC, 2'h1)
      |=> s_r.st == esb_pkg::ST_SRC && s_r.idx == 2'h2)
      else $error("source level count wrong");
   chk_ss_phase_one: assert property (paramByte(esb_pkg::ST_SS, 2'h0)
      |=> softstartPhases[7:0] == $past(hostByte))
      else $error("phase one byte not stored");
   chk_ss_phase_two: assert property (paramByte(esb_pkg::ST_SS, 2'h1)
      |=> softstartPhases[15:8] == $past(hostByte))
      else $error("phase two byte not stored");
   chk_ss_phase_three: assert property (paramByte(esb_pkg::ST_SS, 2'h2)
      |=> softstartPhases[23:16] == $past(hostByte) && s_r.idx == 2'h3)
      else $error("phase three byte not stored");
   chk_ics_shift: assert property (paramByte(esb_pkg::ST_ICW, 2'h0)
      |=> initialCodeSel[7:0] == $past(hostByte) && s_r.idx == 2'h1)
      else $error("initial code byte not shifted in");
   chk_ics_done: assert property (paramByte(esb_pkg::ST_ICW, 2'h3) |=> s_r.st == esb_pkg::ST_IDLE)
      else $error("initial code write did not end");

   // parameters only move when their own command owns the byte
   chk_levels_hold: assert property (!(dataTaken && s_r.st == esb_pkg::ST_SRC)
      |=> $stable(firstHighSourceLevel) && $stable(secondHighSourceLevel)
      && $stable(negativeSourceLevel))
      else $error("source level changed without its command");
   chk_ics_hold: assert property (!(dataTaken && s_r.st == esb_pkg::ST_ICW)
      |=> $stable(initialCodeSel))
      else $error("initial code changed without its command");
   chk_ss_hold: assert property (!(dataTaken && s_r.st == esb_pkg::ST_SS)
      |=> $stable(softstartPhases) && $stable(softstartDurations))
      else $error("soft start changed without its command");
   chk_busy_drops: assert property (busy && hostValid |=> $stable(firstHighSourceLevel)
      && $stable(initialCodeSel) && $stable(softstartPhases) && !progReq)
      else $error("byte accepted while busy");

   // programming: one request pulse, busy until done, nothing without the gate
   chk_busy_rise: assert property (!busy && !(opTaken && hostByte == esb_pkg::OP_ICS_PROG
      && internalClockGateFlag) |=> !busy)
      else $error("busy rose without a gated program command");
   chk_req_cause: assert property (progReq |-> busy && $past(opTaken)
      && $past(hostByte) == esb_pkg::OP_ICS_PROG && $past(internalClockGateFlag))
      else $error("program request without its command");
   chk_req_busy: assert property (busy && !progReq |=> !progReq)
      else $error("second program request while busy");

   // readback walks A, B, C, D and back to A, one byte per strobe
   sequence readStep(logic [1:0] k);
      s_r.st == esb_pkg::ST_ICR && readStrobe && !hostValid && s_r.idx == k;
   endsequence

   chk_read_b: assert property (readStep(2'h0) |=> readByte == initialCodeSel[23:16])
      else $error("readback second byte wrong");
   chk_read_c: assert property (readStep(2'h1) |=> readByte == initialCodeSel[15:8])
      else $error("readback third byte wrong");
   chk_read_d: assert property (readStep(2'h2) |=> readByte == initialCodeSel[7:0])
      else $error("readback fourth byte wrong");
   chk_read_wrap: assert property (readStep(2'h3) |=> readByte == initialCodeSel[31:24])
      else $error("readback did not wrap");
   chk_read_hold: assert property (s_r.st == esb_pkg::ST_ICR && !readStrobe && !hostValid
      |=> $stable(readByte))
      else $error("readback byte moved without strobe");

   // range flags come from the stored code, not from the last byte sent
   chk_upper_valid: assert property (firstHighValid
      |-> firstHighUpper && firstHighSourceLevel <= esb_pkg::HI_UPPER_MAX)
      else $error("first high level flagged outside upper range");
   chk_lower_valid: assert property (secondHighValid && secondHighLower
      |-> secondHighSourceLevel >= esb_pkg::HI_LOWER_MIN
      && secondHighSourceLevel <= esb_pkg::HI_LOWER_MAX)
      else $error("second high level flagged outside lower range");
   chk_neg_valid: assert property (negativeValid |-> !negativeSourceLevel[esb_pkg::RANGE_BIT])
      else $error("low level flagged with range bit set");
   chk_off_valid: assert property (offTimeValid[0]
      |-> boosterGateDriveOffTime[3:0] >= esb_pkg::OFF_MIN)
      else $error("off time flagged below minimum");
   chk_strength_map: assert property (boosterDriveStrength[8:6] == softstartPhases[22:20]
      && boosterDriveStrength[2:0] == softstartPhases[6:4])
      else $error("drive strength field misplaced");
   chk_len_short: assert property (softstartDurations[1:0] == 2'h0
      |-> phaseLenMs[5:0] == esb_pkg::DUR_STEP_MS)
      else $error("shortest phase length wrong");
   chk_len_long: assert property (softstartDurations[5:4] == 2'h3
      |-> phaseLenMs[17:12] == 6'h28)
      else $error("longest phase length wrong");
endmodule

//--- test/esb_cmd_decoder_tb.sv
module esb_cmd_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic gateFlag = 1'b0;
   logic progDone = 1'b0;
   logic hostValid, hostDc, readStrobe, progReq, busy, fu, sl, fv, sv, nv;
   logic [7:0] hostByte, readByte, fh, sh, nl, dur;
   logic [31:0] ics;
   logic [23:0] ssp;
   logic [8:0] str;
   logic [11:0] offT;
   logic [2:0] offV;
   logic [17:0] lenMs;
   int errorCnt = 0;
   int nCompared = 0;
   // level rows probe range ends; only the last puts second high in its upper range
   logic [7:0] lv [3][3] = '{'{8'h4B, 8'hCC, 8'h0F}, '{8'h21, 8'h8E, 8'h4C}, '{8'h22, 8'h21, 8'h0E}};
   logic [4:0] fl [3] = '{5'h1F, 5'h1E, 5'h16};
   logic [31:0] rb = 32'hADBEEFDE;
   always #10 ref_clk = ~ref_clk;
   esb_host_model u_host (.ref_clk(ref_clk), .hostValid(hostValid), .hostDc(hostDc), .hostByte(hostByte),
      .readStrobe(readStrobe));
   esb_cmd_decoder u_dut (.ref_clk(ref_clk), .nrst(nrst), .hostValid(hostValid), .hostDc(hostDc),
      .hostByte(hostByte), .readStrobe(readStrobe), .internalClockGateFlag(gateFlag), .progDone(progDone),
      .progReq(progReq), .busy(busy), .readByte(readByte), .firstHighSourceLevel(fh),
      .secondHighSourceLevel(sh), .negativeSourceLevel(nl), .firstHighUpper(fu), .secondHighLower(sl),
      .firstHighValid(fv), .secondHighValid(sv), .negativeValid(nv), .initialCodeSel(ics),
      .softstartPhases(ssp), .softstartDurations(dur), .boosterDriveStrength(str),
      .boosterGateDriveOffTime(offT), .offTimeValid(offV), .phaseLenMs(lenMs));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // parameters go out most significant byte first
   task automatic cmd(input logic [7:0] op, input logic [31:0] prm, input int n);
      u_host.send(1'b0, op);
      for (int i = n - 1; i >= 0; i--) begin
         u_host.send(1'b1, prm[8*i +: 8]);
      end
      u_host.idle(1);
   endtask
   task automatic finishTest;
      $display("compared %0d mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      errorCnt++;
      finishTest();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      #1 nrst = 1'b1;
      check("levels", {fh, sh, nl}, 32'h0041A832);
      check("phases", ssp, 32'h00969C8B);
      check("durations", dur, 8'h0F);
      check("strength offtime", {str, offT, offV}, {9'h048, 12'h6CB, 3'h7});
      check("phase length", lenMs, {6'h0A, 6'h28, 6'h28});
      check("idle busy", {busy, progReq, readByte}, 10'h000);
      $display("reset test done");
      for (int i = 0; i < 3; i++) begin
         cmd(esb_pkg::OP_SRC_LEVEL, {8'h00, lv[i][0], lv[i][1], lv[i][2]}, 3);
         check("levels", {fh, sh, nl}, {lv[i][0], lv[i][1], lv[i][2]});
         check("level flags", {fu, sl, fv, sv, nv}, fl[i]);
      end
      cmd(8'h05, 32'h1234, 2);
      check("unknown op", {fh, sh, nl}, 32'h0022210E);
      $display("source level test done");
      // first three bytes carry bit 7, fourth has bits 7:6 clear
      cmd(esb_pkg::OP_SOFTSTART, 32'hF483FF24, 4);
      check("phases", {ssp, dur}, 32'hFF83F424);
      check("strength offtime", {str, offT, offV}, {9'h1C7, 12'hF34, 3'h5});
      check("phase length", lenMs, {6'h1E, 6'h14, 6'h0A});
      $display("soft start test done");
      cmd(esb_pkg::OP_ICS_WRITE, 32'hDEADBEEF, 4);
      check("initial code", ics, 32'hDEADBEEF);
      cmd(esb_pkg::OP_ICS_READ, 32'h0, 0);
      check("read first", readByte, 8'hDE);
      for (int i = 0; i < 4; i++) begin
         u_host.strobe();
         check("read next", readByte, rb[31-8*i -: 8]);
      end
      $display("initial code test done");
      cmd(esb_pkg::OP_ICS_PROG, 32'h0, 0);
      check("gate off", {busy, progReq}, 2'b00);
      gateFlag = 1'b1;
      u_host.send(1'b0, esb_pkg::OP_ICS_PROG);
      check("prog start", {busy, progReq}, 2'b11);
      cmd(esb_pkg::OP_SRC_LEVEL, 32'h55, 1);
      check("busy hold", {busy, progReq, fh}, 10'h222);
      progDone = 1'b1;
      @(posedge ref_clk);
      #1 progDone = 1'b0;
      check("prog end", busy, 1'b0);
      $display("program test done");
      finishTest();
   end
endmodule

//--- test/esb_host_model.sv
module esb_host_model (
   input wire logic ref_clk,
   output logic hostValid,
   output logic hostDc,
   output logic [7:0] hostByte,
   output logic readStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hostValid = 1'b0;
      hostDc = 1'b1;
      hostByte = 8'h00;
      readStrobe = 1'b0;
   end
   // opcode with select low, parameters with select high, writes only
   task automatic send(input logic dc, input logic [7:0] b);
      hostValid = 1'b1;
      hostDc = dc;
      hostByte = b;
      @(posedge ref_clk);
      #1;
   endtask
   // released lane toggles so a stale byte is never mistaken for data
   task automatic idle(input int n);
      hostValid = 1'b0;
      repeat (n) begin
         hostByte = ~hostByte;
         @(posedge ref_clk);
         #1;
      end
   endtask
   task automatic strobe;
      readStrobe = 1'b1;
      @(posedge ref_clk);
      #1;
      readStrobe = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
endmodule
